/* pvo_pkg.sv */
/*
 * Shared constants for the parallel value output port: register map,
 * field positions, reset values and timing counts.
 * Assumes a 40 MHz core clock and a 32-bit AHB-Lite register bus.
 */
`default_nettype none
package pvo_pkg;
	// ------------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------------
	localparam int unsigned CLK_HZ       = 40_000_000;
	localparam int unsigned BAUD_HZ      = 115_200;
	localparam int unsigned BAUD_DIV     = CLK_HZ / BAUD_HZ;
	localparam int unsigned UART_BITS    = 8;
	localparam logic [31:0] PERIOD_RST   = 32'h0000_9C40;
	localparam logic [31:0] PERIOD_MIN   = 32'h0000_0006;
	// ------------------------------------------------------------------
	// Word layout
	// ------------------------------------------------------------------
	localparam int unsigned OUT_W        = 25;
	localparam int unsigned TOP_BIT      = 24;
	localparam int unsigned SEC_BIT      = 23;
	// ------------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_PERIOD    = 8'h04;
	localparam logic [7:0] OFS_VALUE     = 8'h08;
	localparam logic [7:0] OFS_STATUS    = 8'h0C;
	localparam logic [7:0] OFS_IRQ_CLR   = 8'h10;
	localparam logic [7:0] OFS_IRQ_EN    = 8'h14;
	localparam logic [7:0] OFS_TX        = 8'h18;
	localparam logic [7:0] OFS_RX        = 8'h1C;
	localparam logic [7:0] OFS_PINS      = 8'h20;
	// ------------------------------------------------------------------
	// Control fields and status bits
	// ------------------------------------------------------------------
	localparam int unsigned CTL_ERR_EN   = 0;
	localparam int unsigned CTL_STB_EN   = 1;
	localparam int unsigned CTL_ERR_HI   = 2;
	localparam int unsigned CTL_STB_HI   = 3;
	localparam logic [3:0]  CTRL_RST     = 4'h0;
	localparam int unsigned ST_UPDATE    = 0;
	localparam int unsigned ST_RX        = 1;
	localparam int unsigned ST_TX        = 2;
	localparam int unsigned IRQ_W        = 3;
endpackage
`default_nettype wire

/* pvo_top.sv */
/*
 * Parallel value output port with a data-settled and an error indicator
 * on its top bits, registers over AHB-Lite, and the fixed serial link.
 * Assumes a single 40 MHz core clock, one AHB-Lite master with single
 * word transfers, and an error level from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module pvo_top
	import pvo_pkg::*;
(
	input  wire logic        CORE_CLK,
	input  wire logic        RST_N,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	input  wire logic        ERR_DETECT,
	output logic [OUT_W-1:0] PAR_OUT,
	input  wire logic        CFG_RX,
	output logic             CFG_TX,
	output logic             IRQ
);
	// ------------------------------------------------------------------
	// Types and state
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		S_STABLE = 3'h1,
		S_OPEN   = 3'h2,
		S_LOAD   = 3'h4
	} upd_state_t;

	upd_state_t       state_q, state_d;
	logic [3:0]       ctrl_q;
	logic [31:0]      period_q;
	logic [OUT_W-1:0] value_q;
	logic [OUT_W-1:0] data_q, data_d;
	logic [31:0]      cnt_q, cnt_d;
	logic [IRQ_W-1:0] stat_q, irq_en_q;
	logic [7:0]       tx_byte_q, rx_byte_q;
	logic             tx_go_q, rx_full_q;
	logic             wr_pend_q;
	logic [7:0]       wr_addr_q;
	logic [31:0]      stb_len_q;

	wire              tx_busy, tx_done, rx_valid, tx_line;
	wire [7:0]        rx_byte;

	// ------------------------------------------------------------------
	// Output word composition
	// ------------------------------------------------------------------
	// Value bits fill whatever the indicators leave free, so the value
	// loses its top bit for each indicator switched on.
	function automatic logic [OUT_W-1:0] compose(
		input logic [OUT_W-1:0] val,
		input logic             settled,
		input logic             err,
		input logic [3:0]       ctl
	);
		logic [OUT_W-1:0] w;
		logic             err_lvl, stb_lvl;
		w       = val;
		err_lvl = err ~^ ctl[CTL_ERR_HI];
		stb_lvl = settled ~^ ctl[CTL_STB_HI];
		if (ctl[CTL_STB_EN]) begin
			w[TOP_BIT] = stb_lvl;
			if (ctl[CTL_ERR_EN]) begin
				w[SEC_BIT] = err_lvl;
			end
		end else if (ctl[CTL_ERR_EN]) begin
			w[TOP_BIT] = err_lvl;
		end
		return w;
	endfunction

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	wire        addr_ok  = HSEL && HREADY && HTRANS[1];
	wire        rd_req   = addr_ok && !HWRITE;
	wire        wr_req   = addr_ok && HWRITE;
	wire [7:0]  a_ofs    = HADDR[7:0];
	wire        wr_ctrl  = wr_pend_q && wr_addr_q == OFS_CTRL;
	wire        wr_per   = wr_pend_q && wr_addr_q == OFS_PERIOD;
	wire        wr_val   = wr_pend_q && wr_addr_q == OFS_VALUE;
	wire        wr_clr   = wr_pend_q && wr_addr_q == OFS_IRQ_CLR;
	wire        wr_en    = wr_pend_q && wr_addr_q == OFS_IRQ_EN;
	wire        wr_tx    = wr_pend_q && wr_addr_q == OFS_TX;
	wire        rd_rx    = rd_req && a_ofs == OFS_RX;
	wire [31:0] per_in   = (HWDATA < PERIOD_MIN) ? PERIOD_MIN : HWDATA;
	wire [31:0] stat_rd  = {29'h0, stat_q};
	wire [31:0] en_rd    = {29'h0, irq_en_q};
	wire [31:0] rx_rd    = {23'h0, rx_full_q, rx_byte_q};
	wire [31:0] pins_rd  = {7'h0, PAR_OUT};
	wire [31:0] val_rd   = {7'h0, value_q};
	wire [31:0] ctrl_rd  = {28'h0, ctrl_q};
	wire [31:0] tx_rd    = {31'h0, tx_busy};

	// Read mux; unmapped and write-only offsets read as zero.
	wire [31:0] rd_mux =
		(a_ofs == OFS_CTRL)   ? ctrl_rd  :
		(a_ofs == OFS_PERIOD) ? period_q :
		(a_ofs == OFS_VALUE)  ? val_rd   :
		(a_ofs == OFS_STATUS) ? stat_rd  :
		(a_ofs == OFS_IRQ_EN) ? en_rd    :
		(a_ofs == OFS_TX)     ? tx_rd    :
		(a_ofs == OFS_RX)     ? rx_rd    :
		(a_ofs == OFS_PINS)   ? pins_rd  : 32'h0000_0000;

	// ------------------------------------------------------------------
	// AHB-Lite slave: zero wait states, always OKAY
	// ------------------------------------------------------------------
	// Read data are captured in the address phase so they stand from a
	// flop for the whole data phase.
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			HRDATA    <= 32'h0000_0000;
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else begin
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
			wr_pend_q <= wr_req;
			wr_addr_q <= a_ofs;
			if (rd_req) begin
				HRDATA <= rd_mux;
			end
		end
	end

	// Register writes land in the data phase.
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_q    <= CTRL_RST;
			period_q  <= PERIOD_RST;
			value_q   <= '0;
			irq_en_q  <= '0;
			tx_byte_q <= 8'h00;
			tx_go_q   <= 1'b0;
		end else begin
			tx_go_q <= wr_tx && !tx_busy;
			if (wr_ctrl)
				ctrl_q <= HWDATA[3:0];
			if (wr_per)
				period_q <= per_in;
			if (wr_val)
				value_q <= HWDATA[OUT_W-1:0];
			if (wr_en)
				irq_en_q <= HWDATA[IRQ_W-1:0];
			if (wr_tx)
				tx_byte_q <= HWDATA[7:0];
		end
	end

	// ------------------------------------------------------------------
	// Update sequencer
	// ------------------------------------------------------------------
	// The settled phase holds period-2 cycles; the floor on the period
	// keeps that at or above a third of the interval.
	wire [31:0] hold_len = period_q - 32'h0000_0002;

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q + 32'h0000_0001;
		data_d  = data_q;
		unique case (state_q)
			S_STABLE: begin
				if (cnt_q + 32'h0000_0001 >= hold_len) begin
					state_d = S_OPEN;
					cnt_d   = 32'h0000_0000;
				end
			end
			// The new word is taken at the edge into the load cycle, so
			// the lines move one cycle after the trailing edge and one
			// cycle before the indicator asserts again.
			S_OPEN: begin
				data_d  = value_q;
				state_d = S_LOAD;
			end
			S_LOAD: begin
				state_d = S_STABLE;
				cnt_d   = 32'h0000_0000;
			end
			default: begin
				state_d = S_OPEN;
				cnt_d   = 32'h0000_0000;
			end
		endcase
	end

	// Pins are built from next-state values so they follow the state
	// flops exactly; the error level lags its input by one cycle.
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_q <= S_OPEN;
			cnt_q   <= 32'h0000_0000;
			data_q  <= '0;
			PAR_OUT <= '0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			data_q  <= data_d;
			PAR_OUT <= compose(data_d, state_d == S_STABLE, ERR_DETECT,
				ctrl_q);
		end
	end

	// ------------------------------------------------------------------
	// Configuration link
	// ------------------------------------------------------------------
	pvo_uart u_uart (
		.clk      (CORE_CLK),
		.rst_n    (RST_N),
		.rx_pin   (CFG_RX),
		.tx_go    (tx_go_q),
		.tx_byte  (tx_byte_q),
		.tx_pin   (tx_line),
		.tx_busy  (tx_busy),
		.tx_done  (tx_done),
		.rx_valid (rx_valid),
		.rx_byte  (rx_byte)
	);

	// ------------------------------------------------------------------
	// Events, receive holding register and interrupt
	// ------------------------------------------------------------------
	wire              upd_evt  = state_q == S_LOAD;
	wire [IRQ_W-1:0]  evt      = {tx_done, rx_valid, upd_evt};
	wire [IRQ_W-1:0]  clr_mask = wr_clr ? HWDATA[IRQ_W-1:0] : '0;

	// A set in the same cycle as its clear wins.
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			stat_q    <= '0;
			rx_byte_q <= 8'h00;
			rx_full_q <= 1'b0;
			IRQ       <= 1'b0;
			CFG_TX    <= 1'b1;
		end else begin
			stat_q <= (stat_q & ~clr_mask) | evt;
			IRQ    <= |(((stat_q & ~clr_mask) | evt) & irq_en_q);
			CFG_TX <= tx_line;
			if (rx_valid) begin
				rx_byte_q <= rx_byte;
				rx_full_q <= 1'b1;
			end else if (rd_rx) begin
				rx_full_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	// Length of the current settled phase, for the minimum-width check.
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N)
			stb_len_q <= 32'h0000_0000;
		else if (state_q == S_STABLE)
			stb_len_q <= stb_len_q + 32'h0000_0001;
		else
			stb_len_q <= 32'h0000_0000;
	end

	a_data_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		(state_q == S_STABLE && $past(state_q) == S_STABLE)
		|-> $stable(data_q))
		else $error("data moved while the settled indicator was asserted");

	a_trail_valid: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		(state_q == S_STABLE ##1 state_q == S_OPEN) |-> $stable(data_q))
		else $error("data not valid at the settled trailing edge");

	a_stable_min: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		(state_q == S_STABLE && state_d == S_OPEN && $stable(period_q))
		|-> (3 * (stb_len_q + 32'h1) >= period_q))
		else $error("settled interval shorter than a third of the period");

	a_settle_pin: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		(ctrl_q[CTL_STB_EN] && $stable(ctrl_q))
		|-> PAR_OUT[TOP_BIT] == ((state_q == S_STABLE) == ctrl_q[CTL_STB_HI]))
		else $error("settled pin level does not match state and polarity");

	a_err_top: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		(ctrl_q[CTL_ERR_EN] && !ctrl_q[CTL_STB_EN] && ERR_DETECT)
		##1 $stable(ctrl_q) |-> PAR_OUT[TOP_BIT] == ctrl_q[CTL_ERR_HI])
		else $error("error pin not asserted after a detected error");

	a_err_moved: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		(ctrl_q[CTL_ERR_EN] && ctrl_q[CTL_STB_EN]) ##1 $stable(ctrl_q)
		|-> PAR_OUT[SEC_BIT] == ($past(ERR_DETECT) ~^ ctrl_q[CTL_ERR_HI]))
		else $error("error indicator not on the second bit");

	a_value_bits: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		state_q == S_LOAD |-> PAR_OUT[SEC_BIT-1:0] == $past(value_q[SEC_BIT-1:0]))
		else $error("low output bits do not carry the value");

	a_free_top: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		(ctrl_q == 4'h0 && $past(ctrl_q) == 4'h0 && $past(state_q) != S_OPEN)
		|-> PAR_OUT == data_q)
		else $error("output word differs from the value with no indicators");

	a_update_gap: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		(state_q == S_OPEN) |=> (state_q == S_LOAD) ##1 (state_q == S_STABLE))
		else $error("update window did not close in two cycles");
endmodule
`default_nettype wire

/* pvo_uart.sv */
/*
 * Fixed-format configuration serial link: 8 data bits, no parity,
 * one stop bit at a fixed baud rate, with no way to alter them.
 * Assumes the receive pin is asynchronous to the core clock.
 */
`timescale 1ns/1ps
`default_nettype none
module pvo_uart
	import pvo_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       rx_pin,
	input  wire logic       tx_go,
	input  wire logic [7:0] tx_byte,
	output logic            tx_pin,
	output logic            tx_busy,
	output logic            tx_done,
	output logic            rx_valid,
	output logic [7:0]      rx_byte
);
	// ------------------------------------------------------------------
	// Receive pin synchroniser
	// ------------------------------------------------------------------
	logic        rx_s1_q, rx_s2_q;
	logic [15:0] rx_cnt_q, tx_cnt_q;
	logic [3:0]  rx_bit_q, tx_bit_q;
	logic [9:0]  tx_sh_q;
	logic [7:0]  rx_sh_q;
	logic        rx_act_q;
	wire  [15:0] div_full = 16'(BAUD_DIV - 1);
	wire  [15:0] div_half = 16'(BAUD_DIV / 2);

	// Two flops before any logic sees the pin.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
		end else begin
			rx_s1_q <= rx_pin;
			rx_s2_q <= rx_s1_q;
		end
	end

	// ------------------------------------------------------------------
	// Receiver: samples mid-bit, drops frames with a low stop bit
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_act_q <= 1'b0;
			rx_cnt_q <= 16'h0000;
			rx_bit_q <= 4'h0;
			rx_sh_q  <= 8'h00;
			rx_valid <= 1'b0;
			rx_byte  <= 8'h00;
		end else begin
			rx_valid <= 1'b0;
			if (!rx_act_q) begin
				if (!rx_s2_q) begin
					rx_act_q <= 1'b1;
					rx_cnt_q <= div_half;
					rx_bit_q <= 4'h0;
				end
			end else if (rx_cnt_q != 16'h0000) begin
				rx_cnt_q <= rx_cnt_q - 16'h0001;
			end else begin
				rx_cnt_q <= div_full;
				rx_bit_q <= rx_bit_q + 4'h1;
				if (rx_bit_q == 4'h0 && rx_s2_q) begin
					rx_act_q <= 1'b0; // Glitch, not a start bit.
				end else if (rx_bit_q == 4'(UART_BITS + 1)) begin
					rx_act_q <= 1'b0;
					rx_valid <= rx_s2_q;
					rx_byte  <= rx_sh_q;
				end else if (rx_bit_q != 4'h0) begin
					rx_sh_q <= {rx_s2_q, rx_sh_q[7:1]};
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Transmitter: start, eight bits LSB first, stop
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_sh_q  <= 10'h3FF;
			tx_cnt_q <= 16'h0000;
			tx_bit_q <= 4'h0;
			tx_busy  <= 1'b0;
			tx_done  <= 1'b0;
			tx_pin   <= 1'b1;
		end else begin
			tx_done <= 1'b0;
			if (!tx_busy) begin
				if (tx_go) begin
					tx_sh_q  <= {1'b1, tx_byte, 1'b0};
					tx_busy  <= 1'b1;
					tx_cnt_q <= div_full;
					tx_bit_q <= 4'h0;
					tx_pin   <= 1'b0;
				end
			end else if (tx_cnt_q != 16'h0000) begin
				tx_cnt_q <= tx_cnt_q - 16'h0001;
			end else if (tx_bit_q == 4'(UART_BITS + 1)) begin
				tx_busy <= 1'b0;
				tx_done <= 1'b1;
			end else begin
				tx_cnt_q <= div_full;
				tx_bit_q <= tx_bit_q + 4'h1;
				tx_pin   <= tx_sh_q[tx_bit_q + 4'h1];
			end
		end
	end

	// The line only moves on a bit boundary, so every bit lasts one baud.
	a_tx_bit_len: assert property (@(posedge clk) disable iff (!rst_n)
		(tx_busy && tx_cnt_q != 16'h0000) |=> $stable(tx_pin))
		else $error("serial line moved inside a bit time");
endmodule
`default_nettype wire

/* remote_ctl.sv */
/*
 * Remote controller model: latches the parallel word on the trailing
 * edge of the settled indicator and receives bytes on the serial link.
 * Assumes the bench tells it which settled polarity is selected.
 */
`timescale 1ns/1ps
`default_nettype none
module remote_ctl
	import pvo_pkg::*;
(
	input  wire logic             clk,
	input  wire logic [OUT_W-1:0] par,
	input  wire logic             pol_hi,
	input  wire logic             tx_line,
	output logic      [OUT_W-1:0] word,
	output logic      [15:0]      n_latch,
	output logic      [7:0]       rx_b,
	output logic      [15:0]      n_rx,
	output logic                  stop_ok
);
	// ------------------------------------------------------------------
	// Latch and receive
	// ------------------------------------------------------------------
	// Latch on the indicator edge itself, as a real controller would.
	initial begin
		word = '0;
		n_latch = '0;
		forever begin
			@(par[TOP_BIT]);
			if (par[TOP_BIT] === !pol_hi) begin
				word = par;
				n_latch = n_latch + 16'h1;
			end
		end
	end
	// Sample mid-cell; a late stop bit shows as stop_ok low.
	initial begin
		rx_b = '0;
		n_rx = '0;
		stop_ok = 1'b0;
		forever begin
			@(negedge tx_line);
			repeat (BAUD_DIV / 2) @(posedge clk);
			for (int i = 0; i < UART_BITS; i++) begin
				repeat (BAUD_DIV) @(posedge clk);
				rx_b[i] = tx_line;
			end
			repeat (BAUD_DIV) @(posedge clk);
			stop_ok = tx_line;
			n_rx = n_rx + 16'h1;
		end
	end
endmodule
`default_nettype wire

/* testbench.sv */
/*
 * Self-checking bench for the parallel value output port.
 * Assumes pvo_top and remote_ctl are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench
	import pvo_pkg::*;
;
	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	logic             clk, rst_n, hsel, hwrite, err_det, cfg_rx, e, mon_on;
	logic [31:0]      haddr, hwdata, v, q;
	logic [1:0]       htrans;
	logic [3:0]       ctl_m;
	wire  [31:0]      hrdata;
	wire              hreadyout, hresp, cfg_tx, irq, stop_ok;
	wire  [OUT_W-1:0] par, lw;
	wire  [15:0]      n_latch, n_rx;
	wire  [7:0]       rx_b;
	logic [SEC_BIT:0] prev;
	int               mismatches, n_tests, seed, period_m, run, nrun;
	// Half period of 12.5 ns gives the 40 MHz core clock.
	always #12.5 clk = ~clk;
	pvo_top uut (.CORE_CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
		.HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
		.HRESP(hresp), .ERR_DETECT(err_det), .PAR_OUT(par), .CFG_RX(cfg_rx),
		.CFG_TX(cfg_tx), .IRQ(irq));
	remote_ctl far (.clk(clk), .par(par), .pol_hi(ctl_m[CTL_STB_HI]),
		.tx_line(cfg_tx), .word(lw), .n_latch(n_latch), .rx_b(rx_b),
		.n_rx(n_rx), .stop_ok(stop_ok));
	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Bounded wait: 0 latch count, 1 byte count, 2 interrupt high.
	task automatic wait_for(input int sel, input logic [15:0] tgt);
		int i;
		for (i = 0; i < 5000; i++) begin
			@(posedge clk);
			if (sel == 0 ? n_latch >= tgt : sel == 1 ? n_rx >= tgt : irq === 1'b1) begin
				break;
			end
		end
		if (i == 5000) begin
			mismatches++;
			end_sim;
		end
	endtask
	// Bounded wait for ready at a rising edge; running out ends the run.
	task automatic wait_rdy;
		int i;
		for (i = 0; i < 100; i++) begin
			@(posedge clk);
			if (hreadyout === 1'b1) begin
				break;
			end
		end
		if (i == 100) begin
			mismatches++;
			end_sim;
		end
	endtask
	// One single AHB-Lite word transfer; ready is polled, never assumed.
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= wr;
		wait_rdy;
		htrans <= 2'b00;
		hwdata <= d;
		wait_rdy;
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int k = 0; k < 10; k++) begin
			@(posedge clk);
			cfg_rx <= f[k];
			repeat (BAUD_DIV - 1) @(posedge clk);
		end
	endtask
	// Expected word; the settled bit shows its deasserted level at a latch.
	function automatic logic [24:0] exp_word(input logic [24:0] val,
		input logic er, input logic [3:0] c);
		logic [24:0] w;
		int n;
		n = c[CTL_ERR_EN] + c[CTL_STB_EN];
		w = val & ((25'h1 << (OUT_W - n)) - 25'h1);
		if (c[CTL_STB_EN]) w[TOP_BIT] = !c[CTL_STB_HI];
		if (c[CTL_ERR_EN]) w[c[CTL_STB_EN] ? SEC_BIT : TOP_BIT] = er ~^ c[CTL_ERR_HI];
		return w;
	endfunction
	// Settled intervals: data frozen, and each one after the first long enough.
	always @(negedge clk) begin
		if (!mon_on) begin
			run = 0;
			nrun = 0;
		end else if (par[TOP_BIT] === ctl_m[CTL_STB_HI]) begin
			if (run > 0) check(32'(par[SEC_BIT:0]), 32'(prev));
			run = run + 1;
			prev = par[SEC_BIT:0];
		end else if (run > 0) begin
			if (nrun > 0) check(32'(run >= period_m / 3), 32'h1);
			nrun = nrun + 1;
			run = 0;
		end
	end
	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		{clk, rst_n, hwrite, err_det, mon_on, htrans, haddr, hwdata} = '0;
		{hsel, cfg_rx} = 2'b11;
		{mismatches, n_tests, ctl_m} = '0;
		seed = 12;
		period_m = 40000;
		repeat (12) @(posedge clk);
		@(negedge clk);
		check(32'(par), 32'h0);
		check(32'(cfg_tx), 32'h1);
		@(posedge clk);
		rst_n <= 1'b1;
		bus(1'b0, OFS_CTRL, 32'h0, q);
		check(q, {28'h0, CTRL_RST});
		bus(1'b0, OFS_PERIOD, 32'h0, q);
		check(q, PERIOD_RST);
		bus(1'b0, 8'h24, 32'h0, q);
		check(q, 32'h0);
		wr(OFS_PERIOD, 32'h3);
		bus(1'b0, OFS_PERIOD, 32'h0, q);
		check(q, PERIOD_MIN);
		wr(OFS_PERIOD, 32'h9);
		period_m = 9;
		$display("test registers done");
		for (int c = 0; c < 16; c++) begin
			mon_on = 1'b0;
			ctl_m = 4'(c);
			v = $random(seed);
			e = v[31];
			wr(OFS_CTRL, 32'(c));
			wr(OFS_VALUE, {7'h0, v[24:0]});
			err_det <= e;
			if (ctl_m[CTL_STB_EN]) begin
				wait_for(0, n_latch + 16'h3);
				mon_on = 1'b1;
				wait_for(0, n_latch + 16'h3);
				check(32'(lw), 32'(exp_word(v[24:0], e, ctl_m)));
			end else begin
				repeat (2 * period_m) @(posedge clk);
				@(negedge clk);
				check(32'(par), 32'(exp_word(v[24:0], e, ctl_m)));
				bus(1'b0, OFS_PINS, 32'h0, q);
				check(q, 32'(exp_word(v[24:0], e, ctl_m)));
			end
		end
		mon_on = 1'b0;
		$display("test parallel word done");
		wr(OFS_IRQ_EN, 32'h4);
		v = $random(seed);
		wr(OFS_TX, {24'h0, v[7:0]});
		wait_for(1, n_rx + 16'h1);
		check(32'(rx_b), 32'(v[7:0]));
		check(32'(stop_ok), 32'h1);
		wait_for(2, 16'h0);
		bus(1'b0, OFS_STATUS, 32'h0, q);
		check(q & 32'h4, 32'h4);
		// The interrupt flop sees a new enable one edge after it lands.
		wr(OFS_IRQ_EN, 32'h0);
		@(posedge clk);
		@(negedge clk);
		check(32'(irq), 32'h0);
		wr(OFS_IRQ_EN, 32'h4);
		@(posedge clk);
		@(negedge clk);
		check(32'(irq), 32'h1);
		wr(OFS_IRQ_CLR, 32'h4);
		@(negedge clk);
		check(32'(irq), 32'h0);
		$display("test transmit done");
		v = $random(seed);
		send(v[7:0]);
		repeat (BAUD_DIV) @(posedge clk);
		bus(1'b0, OFS_RX, 32'h0, q);
		check(q, {23'h0, 1'b1, v[7:0]});
		bus(1'b0, OFS_RX, 32'h0, q);
		check(q & 32'h100, 32'h0);
		bus(1'b0, OFS_STATUS, 32'h0, q);
		check(q & 32'h2, 32'h2);
		$display("test receive done");
		end_sim;
	end
endmodule
`default_nettype wire
